//--- hw/io_mapper_map.svh
`ifndef IO_MAPPER_MAP_SVH
`define IO_MAPPER_MAP_SVH

// register indices (object dictionary style)
`define IDX_INPUT1_SEL   16'h2400
`define IDX_INPUT2_SEL   16'h2401
`define IDX_INPUT3_SEL   16'h2402
`define IDX_INPUT4_SEL   16'h2403
`define IDX_OUTPUT1_SEL  16'h2410
`define IDX_OUTPUT2_SEL  16'h2411
`define IDX_OUTPUT3_SEL  16'h2412

// reset values
`define RST_INPUT1_SEL   8'h00
`define RST_INPUT2_SEL   8'h01
`define RST_INPUT3_SEL   8'h02
`define RST_INPUT4_SEL   8'h16
`define RST_OUTPUT1_SEL  8'h01
`define RST_OUTPUT2_SEL  8'h03
`define RST_OUTPUT3_SEL  8'h04

// selector fields
`define SEL_NC_BIT       7
`define SEL_FUNC_MSB     6

// digital input object bit positions
`define DIN_NEG_LIMIT_BIT 0
`define DIN_POS_LIMIT_BIT 1
`define DIN_HOME_BIT      2
`define DIN_RAW_LSB       4

// digital output object bit positions
`define DOUT_CH_LSB      16

`endif

//--- hw/io_mapper_pkg.sv
`default_nettype none
package io_mapper_pkg;

    typedef enum logic [6:0] {
        IN_NONE        = 7'h00,
        IN_POS_LIMIT   = 7'h01,
        IN_NEG_LIMIT   = 7'h02,
        IN_ALARM_CLEAR = 7'h04,
        IN_FORCE_ALARM = 7'h14,
        IN_HOME        = 7'h16
    } in_func_e;

    typedef enum logic [6:0] {
        OUT_MASTER      = 7'h00,
        OUT_ALARM       = 7'h01,
        OUT_READY       = 7'h02,
        OUT_BRAKE_REL   = 7'h03,
        OUT_IN_POS      = 7'h04,
        OUT_SPEED_REACHED_OUTPUT    = 7'h05,
        OUT_TORQUE_LIM  = 7'h06,
        OUT_ZERO_SPEED  = 7'h07,
        OUT_VEL_MATCH   = 7'h08,
        OUT_POS_CMD     = 7'h0b,
        OUT_SPEED_LIM   = 7'h0d,
        OUT_VEL_CMD     = 7'h0f,
        OUT_SERVO_ON    = 7'h12,
        OUT_POS_LIMIT   = 7'h15,
        OUT_NEG_LIMIT   = 7'h16,
        OUT_HOMING_DONE = 7'h22
    } out_func_e;

    typedef logic [7:0] sel_t;

endpackage
`default_nettype wire

//--- hw/output_channel_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_mapper_map.svh"

module output_channel_driver (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sel,
    input  wire logic [15:0] status,
    input  wire logic        master_level,
    input  wire logic        master_mode,
    output logic             pin
);

    wire logic [6:0] func = sel[`SEL_FUNC_MSB:0];
    wire logic       nc   = sel[`SEL_NC_BIT];
    logic            active;
    logic            pin_next;

    always_comb begin
        case (io_mapper_pkg::out_func_e'(func))
            io_mapper_pkg::OUT_ALARM:       active = status[0];
            io_mapper_pkg::OUT_READY:       active = status[1];
            io_mapper_pkg::OUT_BRAKE_REL:   active = status[2];
            io_mapper_pkg::OUT_IN_POS:      active = status[3];
            io_mapper_pkg::OUT_SPEED_REACHED_OUTPUT:    active = status[4];
            io_mapper_pkg::OUT_TORQUE_LIM:  active = status[5];
            io_mapper_pkg::OUT_ZERO_SPEED:  active = status[6];
            io_mapper_pkg::OUT_VEL_MATCH:   active = status[7];
            io_mapper_pkg::OUT_SERVO_ON:    active = status[8];
            io_mapper_pkg::OUT_POS_LIMIT:   active = status[9];
            io_mapper_pkg::OUT_NEG_LIMIT:   active = status[10];
            io_mapper_pkg::OUT_POS_CMD:     active = status[11];
            io_mapper_pkg::OUT_SPEED_LIM:   active = status[12];
            io_mapper_pkg::OUT_VEL_CMD:     active = status[13];
            io_mapper_pkg::OUT_HOMING_DONE: active = status[14];
            default:                        active = 1'b0;
        endcase
    end

    assign pin_next = master_mode ? master_level : (nc ? active : ~active);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b1;
        end else begin
            pin <= pin_next;
        end
    end

endmodule
`default_nettype wire

//--- hw/servo_io_function_mapper.sv
// Contract
// - input codes map to limits, alarm clear, forced alarm, home; input object bits.
// - open sense asserts on ON; closed sense asserts on OFF.
// - same input function on two channels raises duplicate alarm.
// - unassigned input channel has no effect on motion.
// - selectors govern inputs 1-4; all zero exposes raw inputs to master.
// - inputs 1-4 pair one-to-one with selectors 1-4.
// - input selector resets 0x0, 0x1, 0x2, 0x16.
// - output codes 00h master, 01h-08h and 81h-88h status pairs.
// - further output codes 12h,15h,16h,0Bh,0Dh,0Fh,22h with closed pairs.
// - open-sense output active low, closed-sense active high.
// - outputs 1-3 by selectors; all zero, master bits 16-18 drive.
// - output selector resets 0x01, 0x03, 0x04.
`timescale 1ns/1ps
`default_nettype none
`include "io_mapper_map.svh"

module servo_io_function_mapper (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESETN_IN,
    // parameter access by object index
    input  wire logic        PARAM_WR_IN,
    input  wire logic [15:0] PARAM_INDEX_IN,
    input  wire logic [7:0]  PARAM_WDATA_IN,
    output logic      [7:0]  PARAM_RDATA_OUT,
    output logic             PARAM_HIT_OUT,
    // discrete input pins, high = ON
    input  wire logic [3:0]  INPUT_CHANNEL_IN,
    // drive status, one bit per output function
    input  wire logic [15:0] DRIVE_STATUS_IN,
    // master digital output object sub-index 01
    input  wire logic [31:0] MASTER_DOUT_IN,
    output logic [2:0]       OUTPUT_CHANNEL_OUT,
    output logic [31:0]      DIGITAL_INPUT_OBJ_OUT,
    output logic             POSITIVE_TRAVEL_LIMIT_OUT,
    output logic             NEGATIVE_TRAVEL_LIMIT_OUT,
    output logic             HOME_SWITCH_OUT,
    output logic             ALARM_CLEAR_INPUT_OUT,
    output logic             FORCED_ALARM_OUT,
    output logic             DUPLICATE_ASSIGNMENT_ALARM_OUT
);

    //--------------------------------------------------------------
    // selector registers
    //--------------------------------------------------------------
    // indices and reset values, one entry per channel
    localparam logic [15:0] in_idx [4] = '{
        `IDX_INPUT1_SEL,
        `IDX_INPUT2_SEL,
        `IDX_INPUT3_SEL,
        `IDX_INPUT4_SEL
    };
    localparam logic [15:0] out_idx [3] = '{
        `IDX_OUTPUT1_SEL,
        `IDX_OUTPUT2_SEL,
        `IDX_OUTPUT3_SEL
    };
    localparam logic [7:0]  in_rst [4] = '{
        `RST_INPUT1_SEL,
        `RST_INPUT2_SEL,
        `RST_INPUT3_SEL,
        `RST_INPUT4_SEL
    };
    localparam logic [7:0]  out_rst [3] = '{
        `RST_OUTPUT1_SEL,
        `RST_OUTPUT2_SEL,
        `RST_OUTPUT3_SEL
    };

    logic [7:0] in_sel_reg  [4];
    logic [7:0] out_sel_reg [3];
    logic [3:0] in_hit;
    logic [2:0] out_hit;
    logic [3:0] in_wr;
    logic [2:0] out_wr;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_in
            assign in_hit[g] = (PARAM_INDEX_IN == in_idx[g]);
            assign in_wr[g]  = PARAM_WR_IN && in_hit[g];
            always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    in_sel_reg[g] <= in_rst[g];
                end else if (in_wr[g]) begin
                    in_sel_reg[g] <= PARAM_WDATA_IN;
                end
            end
        end
        for (g = 0; g < 3; g++) begin : g_out
            assign out_hit[g] = (PARAM_INDEX_IN == out_idx[g]);
            assign out_wr[g]  = PARAM_WR_IN && out_hit[g];
            always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    out_sel_reg[g] <= out_rst[g];
                end else if (out_wr[g]) begin
                    out_sel_reg[g] <= PARAM_WDATA_IN;
                end
            end
        end
    endgenerate

    //--------------------------------------------------------------
    // parameter read
    //--------------------------------------------------------------
    // combinational read; unmapped index reads zero with no hit
    logic [7:0] in_rdata;
    logic [7:0] out_rdata;
    always_comb begin
        in_rdata = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (in_hit[i]) begin
                in_rdata = in_sel_reg[i];
            end
        end
    end

    always_comb begin
        out_rdata = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (out_hit[i]) begin
                out_rdata = out_sel_reg[i];
            end
        end
    end

    // indices never overlap, so at most one half is nonzero
    assign PARAM_RDATA_OUT = in_rdata | out_rdata;
    assign PARAM_HIT_OUT   = |{in_hit, out_hit};

    //--------------------------------------------------------------
    // input function decode
    //--------------------------------------------------------------
    logic [3:0] pos_ch;
    logic [3:0] neg_ch;
    logic [3:0] clr_ch;
    logic [3:0] stop_ch;
    logic [3:0] home_ch;
    logic [3:0] asserted;

    generate
        for (g = 0; g < 4; g++) begin : g_dec
            wire logic [6:0] func = in_sel_reg[g][`SEL_FUNC_MSB:0];
            wire logic       nc   = in_sel_reg[g][`SEL_NC_BIT];
            assign asserted[g] = nc ? ~INPUT_CHANNEL_IN[g] : INPUT_CHANNEL_IN[g];
            assign pos_ch[g]  = (func == io_mapper_pkg::IN_POS_LIMIT);
            assign neg_ch[g]  = (func == io_mapper_pkg::IN_NEG_LIMIT);
            assign clr_ch[g]  = (func == io_mapper_pkg::IN_ALARM_CLEAR);
            assign stop_ch[g] = (func == io_mapper_pkg::IN_FORCE_ALARM);
            assign home_ch[g] = (func == io_mapper_pkg::IN_HOME);
        end
    endgenerate

    // true when two or more channels are set
    function automatic logic multi(input logic [3:0] v);
        multi = (v & (v - 4'h1)) != 4'h0;
    endfunction

    //--------------------------------------------------------------
    // duplicate assignment
    //--------------------------------------------------------------
    // either sense of a function counts, so only the 7-bit code is compared
    wire logic dup_pos  = multi(pos_ch);
    wire logic dup_neg  = multi(neg_ch);
    wire logic dup_clr  = multi(clr_ch);
    wire logic dup_stop = multi(stop_ch);
    wire logic dup_home = multi(home_ch);
    wire logic dup      = dup_pos | dup_neg | dup_clr | dup_stop | dup_home;

    // one nonzero selector is enough to hide the raw inputs
    // all selectors zero exposes raw inputs
    wire logic in_all_zero = (in_sel_reg[0] == 8'h00) && (in_sel_reg[1] == 8'h00) &&
                             (in_sel_reg[2] == 8'h00) && (in_sel_reg[3] == 8'h00);

    //--------------------------------------------------------------
    // function levels
    //--------------------------------------------------------------
    // a function on two channels merges by or; the alarm flags it
    wire logic pos_v  = |(pos_ch & asserted);
    wire logic neg_v  = |(neg_ch & asserted);
    wire logic home_v = |(home_ch & asserted);
    // alarm clear has no closed-sense code, bit 7 still honoured
    wire logic clr_v  = |(clr_ch & asserted);
    wire logic stop_v = |(stop_ch & asserted);

    //--------------------------------------------------------------
    // input object
    //--------------------------------------------------------------
    logic [31:0] din_next;
    always_comb begin
        din_next = 32'h0000_0000;
        din_next[`DIN_NEG_LIMIT_BIT] = neg_v;
        din_next[`DIN_POS_LIMIT_BIT] = pos_v;
        din_next[`DIN_HOME_BIT]      = home_v;
        if (in_all_zero) begin
            din_next[`DIN_RAW_LSB +: 4] = INPUT_CHANNEL_IN;
        end
    end

    //--------------------------------------------------------------
    // registered status outputs
    //--------------------------------------------------------------
    // input object register
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            DIGITAL_INPUT_OBJ_OUT <= 32'h0000_0000;
        end else begin
            DIGITAL_INPUT_OBJ_OUT <= din_next;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            POSITIVE_TRAVEL_LIMIT_OUT <= 1'b0;
        end else begin
            POSITIVE_TRAVEL_LIMIT_OUT <= pos_v;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            NEGATIVE_TRAVEL_LIMIT_OUT <= 1'b0;
        end else begin
            NEGATIVE_TRAVEL_LIMIT_OUT <= neg_v;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            HOME_SWITCH_OUT <= 1'b0;
        end else begin
            HOME_SWITCH_OUT <= home_v;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ALARM_CLEAR_INPUT_OUT <= 1'b0;
        end else begin
            ALARM_CLEAR_INPUT_OUT <= clr_v;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            FORCED_ALARM_OUT <= 1'b0;
        end else begin
            FORCED_ALARM_OUT <= stop_v;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            DUPLICATE_ASSIGNMENT_ALARM_OUT <= 1'b0;
        end else begin
            DUPLICATE_ASSIGNMENT_ALARM_OUT <= dup;
        end
    end

    //--------------------------------------------------------------
    // output channels
    //--------------------------------------------------------------
    // master takes over only when all three are zero
    wire logic out_all_zero = (out_sel_reg[0] == 8'h00) && (out_sel_reg[1] == 8'h00) &&
                              (out_sel_reg[2] == 8'h00);
    // master bits pass straight through, no polarity applied
    wire logic [2:0] master_bits = MASTER_DOUT_IN[`DOUT_CH_LSB +: 3];
    // pins idle high through reset, so open-sense loads stay off

    generate
        for (g = 0; g < 3; g++) begin : g_drv
            output_channel_driver u_drv (
                .clk          (SYS_CLK_IN),
                .rst_n        (RESETN_IN),
                .sel          (out_sel_reg[g]),
                .status       (DRIVE_STATUS_IN),
                .master_level (master_bits[g]),
                .master_mode  (out_all_zero),
                .pin          (OUTPUT_CHANNEL_OUT[g])
            );
        end
    endgenerate

endmodule
`default_nettype wire

//--- verif/io_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// switches, relays, drive core, master
// --------
module io_far_side (
    output logic [3:0]  pins_out,
    output logic [15:0] status_out,
    output logic [31:0] master_out
);
    int seed = 76;
    initial begin
        pins_out   = 4'h0;
        status_out = 16'h0;
        master_out = 32'h0;
    end
    task automatic shuffle();
        pins_out   = 4'($random(seed));
        status_out = 16'($random(seed));
        master_out = $random(seed);
    endtask
    task automatic pick(output int n);
        n = {$random(seed)} % 30;
    endtask
    function automatic logic [7:0] in_code_at(input int k);
        logic [7:0] t [10] = '{8'h00, 8'h01, 8'h81, 8'h02, 8'h82, 8'h04, 8'h14, 8'h94, 8'h16, 8'h96};
        return t[k % 10];
    endfunction
    function automatic logic [6:0] out_code_at(input int k);
        logic [6:0] t [15] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
                               7'h12, 7'h15, 7'h16, 7'h0b, 7'h0d, 7'h0f, 7'h22};
        return t[k % 15];
    endfunction
endmodule
`default_nettype wire

//--- verif/io_mapper_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module io_mapper_chk (
    input wire logic        SYS_CLK_IN,
    input wire logic        RESETN_IN,
    input wire logic        PARAM_WR_IN,
    input wire logic [15:0] PARAM_INDEX_IN,
    input wire logic [7:0]  PARAM_WDATA_IN,
    input wire logic [7:0]  PARAM_RDATA_OUT,
    input wire logic        PARAM_HIT_OUT,
    input wire logic [31:0] DIGITAL_INPUT_OBJ_OUT,
    input wire logic        POSITIVE_TRAVEL_LIMIT_OUT,
    input wire logic        NEGATIVE_TRAVEL_LIMIT_OUT,
    input wire logic        HOME_SWITCH_OUT,
    input wire logic [3:0]  INPUT_CHANNEL_IN
);
    default clocking @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    wire mapped = PARAM_INDEX_IN inside {[16'h2400:16'h2403], [16'h2410:16'h2412]};
    property p_pos; DIGITAL_INPUT_OBJ_OUT[1] == POSITIVE_TRAVEL_LIMIT_OUT; endproperty
    a_pos: assert property (p_pos) else $error("positive limit bit differs");
    property p_neg; DIGITAL_INPUT_OBJ_OUT[0] == NEGATIVE_TRAVEL_LIMIT_OUT; endproperty
    a_neg: assert property (p_neg) else $error("negative limit bit differs");
    property p_home; DIGITAL_INPUT_OBJ_OUT[2] == HOME_SWITCH_OUT; endproperty
    a_home: assert property (p_home) else $error("home bit differs");
    property p_spare; DIGITAL_INPUT_OBJ_OUT[31:8] == 24'h0 && !DIGITAL_INPUT_OBJ_OUT[3]; endproperty
    a_spare: assert property (p_spare) else $error("spare input bits set");
    property p_hit; PARAM_HIT_OUT == mapped; endproperty
    a_hit: assert property (p_hit) else $error("hit flag wrong");
    property p_unmapped; !mapped |-> PARAM_RDATA_OUT == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_store; PARAM_WR_IN && mapped |=> $stable(PARAM_INDEX_IN) |-> PARAM_RDATA_OUT == $past(PARAM_WDATA_IN); endproperty
    a_store: assert property (p_store) else $error("write not stored");
    property p_hold; !$past(PARAM_WR_IN) && $stable(PARAM_INDEX_IN) |-> $stable(PARAM_RDATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("selector changed without write");
    property p_raw; (DIGITAL_INPUT_OBJ_OUT[7:4] != 4'h0) |-> DIGITAL_INPUT_OBJ_OUT[7:4] == $past(INPUT_CHANNEL_IN); endproperty
    a_raw: assert property (p_raw) else $error("raw input bits differ");
endmodule
bind servo_io_function_mapper io_mapper_chk chk (.SYS_CLK_IN, .RESETN_IN, .PARAM_WR_IN, .PARAM_INDEX_IN,
    .PARAM_WDATA_IN, .PARAM_RDATA_OUT, .PARAM_HIT_OUT, .DIGITAL_INPUT_OBJ_OUT, .POSITIVE_TRAVEL_LIMIT_OUT,
    .NEGATIVE_TRAVEL_LIMIT_OUT, .HOME_SWITCH_OUT, .INPUT_CHANNEL_IN);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_n;
    logic        wr;
    logic [15:0] idx;
    logic [7:0]  wdata;
    wire  [7:0]  rdata;
    wire         hit;
    wire  [3:0]  pins;
    wire  [15:0] status;
    wire  [31:0] master;
    wire  [2:0]  dout;
    wire  [31:0] din;
    wire  [4:0]  lv;
    wire         dup;
    logic [7:0]  sh [7];
    int          bad_count = 0;
    int          num_checks = 0;
    int          k;
    int          n;
    io_far_side far (.pins_out(pins), .status_out(status), .master_out(master));
    servo_io_function_mapper dut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PARAM_WR_IN(wr), .PARAM_INDEX_IN(idx),
        .PARAM_WDATA_IN(wdata), .PARAM_RDATA_OUT(rdata), .PARAM_HIT_OUT(hit), .INPUT_CHANNEL_IN(pins),
        .DRIVE_STATUS_IN(status), .MASTER_DOUT_IN(master), .OUTPUT_CHANNEL_OUT(dout), .DIGITAL_INPUT_OBJ_OUT(din),
        .POSITIVE_TRAVEL_LIMIT_OUT(lv[4]), .NEGATIVE_TRAVEL_LIMIT_OUT(lv[3]), .HOME_SWITCH_OUT(lv[2]),
        .ALARM_CLEAR_INPUT_OUT(lv[1]), .FORCED_ALARM_OUT(lv[0]), .DUPLICATE_ASSIGNMENT_ALARM_OUT(dup));
    // --------
    // reference model
    // --------
    function automatic logic [2:0] model_out(input logic [23:0] o, input logic [15:0] st, input logic [2:0] m);
        logic [2:0] p;
        logic       a;
        p = m;
        for (int c = 0; c < 3 && o != 24'h0; c++) begin
            a = 1'b0;
            for (int j = 0; j < 15; j++) begin
                a |= (o[c*8 +: 7] == far.out_code_at(j)) & st[j];
            end
            // open sense idles high, closed sense low
            p[c] = a ^ !o[c*8+7];
        end
        return p;
    endfunction
    function automatic logic [9:0] model_in(input logic [31:0] s, input logic [3:0] pin);
        logic [9:0] r;
        logic [6:0] f;
        logic       a;
        r = {6'h0, (s == 32'h0) ? pin : 4'h0};
        for (int c = 0; c < 4; c++) begin
            f = s[c*8 +: 7];
            a = pin[c] ^ s[c*8+7];
            for (int d = c + 1; d < 4; d++) begin
                r[9] |= (f != 7'h0) && (f == s[d*8 +: 7]);
            end
            r[4] |= a && f == 7'h02;
            r[5] |= a && f == 7'h01;
            r[6] |= a && f == 7'h16;
            r[7] |= a && f == 7'h04;
            r[8] |= a && f == 7'h14;
        end
        return r;
    endfunction
    function automatic logic [15:0] idx_of(input int s);
        return (s < 4) ? 16'h2400 + 16'(s) : 16'h2410 + 16'(s - 4);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        sh = '{8'h00, 8'h01, 8'h02, 8'h16, 8'h01, 8'h03, 8'h04};
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic write(input logic [15:0] i, input logic [7:0] d);
        wr = 1'b1;
        idx = i;
        wdata = d;
        @(posedge clk);
        #1;
        for (int s = 0; s < 7; s++) begin
            if (idx_of(s) == i) sh[s] = d;
        end
    endtask
    task automatic settle();
        logic [9:0] mi;
        wr = 1'b0;
        @(posedge clk);
        #1;
        mi = model_in({sh[3], sh[2], sh[1], sh[0]}, pins);
        check("output pins", dout, model_out({sh[6], sh[5], sh[4]}, status, master[18:16]));
        check("duplicate alarm", dup, mi[9]);
        // overlapping functions leave the merged levels open
        if (!mi[9]) begin
            check("input object", din, {24'h0, mi[3:0], 1'b0, mi[6:4]});
            check("input levels", lv, {mi[5], mi[4], mi[6], mi[7], mi[8]});
        end
    endtask
    task automatic read_all();
        for (int s = 0; s < 8; s++) begin
            idx = (s < 7) ? idx_of(s) : 16'h2404;
            @(negedge clk);
            check("read data", rdata, (s < 7) ? sh[s] : 8'h00);
            check("index hit", hit, s < 7);
            @(posedge clk);
            #1;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        check("run length", 32'h1, 32'h0);
        wrap_up();
    end
    initial begin
        wr = 1'b0;
        idx = 16'h0;
        wdata = 8'h0;
        do_reset();
        settle();
        read_all();
        write(16'h2404, 8'h55);
        write(16'h2413, 8'h5a);
        settle();
        read_all();
        // every listed code, both senses, back-to-back writes
        for (k = 0; k < 30; k++) begin
            far.shuffle();
            write(idx_of(k % 4), far.in_code_at(k));
            write(idx_of(4 + k % 3), {k[0], far.out_code_at(k)});
            settle();
        end
        for (k = 0; k < 20; k++) begin
            far.pick(n);
            far.shuffle();
            write(idx_of(n % 7), (n % 7 < 4) ? far.in_code_at(n) : {n[0], far.out_code_at(n)});
            settle();
        end
        read_all();
        for (k = 0; k < 7; k++) begin
            write(idx_of(k), 8'h00);
        end
        for (k = 0; k < 4; k++) begin
            far.shuffle();
            settle();
        end
        do_reset();
        settle();
        read_all();
        wrap_up();
    end
endmodule
`default_nettype wire
